// file: pio_pkg.sv
// shared constants, types and bus carriers for the programmable i/o ports
package pio_pkg;

  // port geometry
  localparam int PORTS       = 4;
  localparam int PORT_W      = 8;
  localparam int NARROW_W    = 3;
  localparam int LOGIC_PORTS = 3;
  localparam logic [7:0] NARROW_MASK = 8'h07;

  // byte offsets inside one port block, and block spacing
  localparam logic [7:0] PORT_STRIDE  = 8'h20;
  localparam logic [7:0] OFS_DATA_IN  = 8'h00;
  localparam logic [7:0] OFS_DATA_OUT = 8'h04;
  localparam logic [7:0] OFS_DIR      = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0c;
  localparam logic [7:0] OFS_ENABLE   = 8'h10;
  localparam logic [7:0] OFS_MACRO    = 8'h14;
  localparam logic [7:0] OFS_IMC      = 8'h18;
  localparam logic [7:0] MODE_REG_OFS = 8'h80;

  // reset values and field positions
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic       MODE_RESET  = 1'b0;
  localparam int         PERIPH_BIT  = 7;

  // pin groups on the third and fourth ports
  localparam logic [7:0] C_MACRO_PINS = 8'h9c;
  localparam logic [7:0] C_JTAG_PINS  = 8'h63;
  localparam logic [7:0] D_ECS_PINS   = 8'h06;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // input macrocell behaviour
  typedef enum logic [1:0] {
    IMC_DIRECT   = 2'b00,
    IMC_LATCH    = 2'b01,
    IMC_REGISTER = 2'b10
  } imc_mode_t;

  // write channel sequencing
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_RESP    = 2'b01
  } wr_state_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage

// file: input_macrocell.sv
// one port's bank of input macrocells: direct, latch or register capture
`timescale 1ns/1ps
module input_macrocell #(
  parameter int                 W          = 8,
  parameter pio_pkg::imc_mode_t MODE       = pio_pkg::IMC_DIRECT,
  parameter logic               USE_STROBE = 1'b1
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pins,
  input  wire logic         i_addr_strobe,
  input  wire logic         i_term_lo,
  input  wire logic         i_term_hi,
  output logic      [W-1:0] o_value
);
  import pio_pkg::*;

  logic [W-1:0] value_r;
  logic [W-1:0] value_nxt;
  logic [W-1:0] en_now;
  logic [W-1:0] en_prev_r;
  logic [W-1:0] en_rise;

  // low half and high half each follow their own product term
  assign en_now  = USE_STROBE ? {W{i_addr_strobe}}
                              : {{(W - W/2){i_term_hi}}, {(W/2){i_term_lo}}};
  assign en_rise = en_now & ~en_prev_r;

  // latch is transparent while enabled; register grabs on the rising enable
  assign value_nxt = (MODE == IMC_LATCH)    ? ((i_pins & en_now) | (value_r & ~en_now)) :
                     (MODE == IMC_REGISTER) ? ((i_pins & en_rise) | (value_r & ~en_rise)) :
                                              i_pins;

  // capture state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      value_r   <= '0;
      en_prev_r <= '0;
    end else begin
      value_r   <= value_nxt;
      en_prev_r <= en_now;
    end
  end

  assign o_value = value_r;

endmodule

// file: programmable_io_ports.sv
// programmable i/o ports: pin multiplexers, drivers, config registers, axi4-lite slave
// Summary of operation
// - four ports: three eight-bit, one three-bit
// - output mux: data out, address, macrocell, selects
// - readback buffer puts one source on bus
// - driver enable is product term or direction
// - no enable term: direction bit alone controls; here a logic output pin without a term drives always
// - three ports have configurable input macrocells
// - logic modes fixed; peripheral and others software-set
// - control bit zero selects processor i/o
// - output pins from data out; inputs readable
// - third, fourth ports lack control, default i/o
// - logic outputs tri-state by term or direction; here those without a term drive always
// - address out needs enable or direction plus control
// - mode bit seven makes first port peripheral buffer
// - peripheral buffer off while selects inactive
// - group two reaches third port pins 2,3,4,7
// - third port jtag pins stay dedicated
// - direction one output, zero input, default input
// - configuration registers reset to zero
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module programmable_io_ports #(
  parameter logic [3:0][7:0] LOGIC_OUT_MASK = '0,
  parameter logic [3:0][7:0] OE_TERM_MASK   = '0,
  parameter logic [7:0]      B_FROM_TWO     = 8'h00,
  parameter logic [2:0][1:0] IMC_MODE       = '0,
  parameter logic [2:0]      IMC_STROBE     = 3'h7
) (
  input  wire logic                i_clock,
  input  wire logic                i_rst,
  input  wire pio_pkg::axil_req_t  i_axil_req,
  output pio_pkg::axil_rsp_t       o_axil_rsp,
  input  wire logic [3:0][7:0]     i_pin,
  output logic      [3:0][7:0]     o_pin,
  output logic      [3:0][7:0]     o_pin_oe_n,
  input  wire logic [3:0][7:0]     i_oe_term,
  input  wire logic [7:0]          i_macro_group_one,
  input  wire logic [7:0]          i_macro_group_two,
  input  wire logic [1:0]          i_external_chip_selects,
  input  wire logic [7:0]          i_latched_addr,
  input  wire logic                i_addr_strobe,
  input  wire logic [2:0][1:0]     i_imc_term,
  input  wire logic                i_periph_select_a,
  input  wire logic                i_periph_select_b,
  input  wire logic [7:0]          i_cpu_data,
  input  wire logic                i_cpu_write,
  output logic      [7:0]          o_periph_data,
  output logic      [2:0][7:0]     o_logic_in
);
  import pio_pkg::*;

  // configuration and data registers
  logic [3:0][7:0] data_out_r;
  logic [3:0][7:0] dir_r;
  logic [1:0][7:0] ctrl_r;
  logic            periph_mode_r;
  logic [3:0][7:0] pin_out_r;
  logic [3:0][7:0] pin_oe_r;
  logic [3:0][7:0] pin_out_nxt;
  logic [3:0][7:0] pin_oe_nxt;
  logic [3:0][7:0] pin_meta_r;
  logic [3:0][7:0] pin_sync_r;
  logic [3:0][7:0] macro_src;
  logic [3:0][7:0] logic_out;
  logic [2:0][7:0] imc_value;
  logic [7:0]      periph_data_r;

  // bus slave state
  wr_state_t   wr_state_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [31:0] wr_addr_r;
  logic [31:0] wr_data_r;
  logic [3:0]  wr_strb_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // address checks; missing control and macrocell blocks answer as unmapped
  function automatic logic reg_ok(input logic [31:0] a);
    logic [7:0] o;
    logic [1:0] p;
    o = {3'b000, a[4:0]};
    p = a[6:5];
    reg_ok = (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) &&
             ((a[7:0] == MODE_REG_OFS) ||
              (!a[7] && (o <= OFS_IMC) && !((o == OFS_CTRL) && p[1]) &&
               !((o == OFS_IMC) && (p == 2'd3))));
  endfunction

  function automatic logic [7:0] port_mask(input logic [1:0] p);
    port_mask = (p == 2'd3) ? NARROW_MASK : 8'hff;
  endfunction

  // one source per read, chosen by offset
  function automatic logic [7:0] readback(input logic [31:0] a);
    logic [7:0] o;
    logic [1:0] p;
    o = {3'b000, a[4:0]};
    p = a[6:5];
    if (a[7])
      readback = {periph_mode_r, 7'h00};
    else if (o == OFS_DATA_IN)
      readback = pin_sync_r[p] & port_mask(p);
    else if (o == OFS_DATA_OUT)
      readback = data_out_r[p];
    else if (o == OFS_DIR)
      readback = dir_r[p];
    else if (o == OFS_CTRL)
      readback = ctrl_r[p[0]];
    else if (o == OFS_ENABLE)
      readback = pin_oe_r[p];
    else if (o == OFS_MACRO)
      readback = macro_src[p] & port_mask(p);
    else
      readback = imc_value[(p == 2'd3) ? 2'd0 : p];
  endfunction

  // handshake decoding
  wire       aw_take = i_axil_req.awvalid && !aw_held_r && (wr_state_r == WR_COLLECT);
  wire       w_take  = i_axil_req.wvalid && !w_held_r && (wr_state_r == WR_COLLECT);
  wire       wr_go   = aw_held_r && w_held_r && (wr_state_r == WR_COLLECT);
  wire       wr_ok   = reg_ok(wr_addr_r);
  wire       wr_en   = wr_go && wr_ok && wr_strb_r[0];
  wire [1:0] wr_port = wr_addr_r[6:5];
  wire [7:0] wr_ofs  = {3'b000, wr_addr_r[4:0]};
  wire [7:0] wr_byte = wr_data_r[7:0] & port_mask(wr_port);
  wire       ar_take = i_axil_req.arvalid && !rvalid_r;

  // write address and data arrive in either order
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_state_r <= WR_COLLECT;
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      wr_addr_r  <= 32'h00000000;
      wr_data_r  <= 32'h00000000;
      wr_strb_r  <= 4'h0;
      bresp_r    <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        wr_addr_r <= i_axil_req.awaddr;
      end
      if (w_take) begin
        w_held_r  <= 1'b1;
        wr_data_r <= i_axil_req.wdata;
        wr_strb_r <= i_axil_req.wstrb;
      end
      case (wr_state_r)
        WR_COLLECT: begin
          if (wr_go) begin
            wr_state_r <= WR_RESP;
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            bresp_r    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (i_axil_req.bready) begin
            wr_state_r <= WR_COLLECT;
          end
        end
        default: wr_state_r <= WR_COLLECT;
      endcase
    end
  end

  // software-writable registers; programmed modes are parameters only
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      data_out_r    <= {PORTS{CFG_RESET}};
      dir_r         <= {PORTS{CFG_RESET}};
      ctrl_r        <= {2{CFG_RESET}};
      periph_mode_r <= MODE_RESET;
    end else if (wr_en && wr_addr_r[7]) begin
      periph_mode_r <= wr_data_r[PERIPH_BIT];
    end else if (wr_en) begin
      case (wr_ofs)
        OFS_DATA_OUT: data_out_r[wr_port] <= wr_byte;
        OFS_DIR:      dir_r[wr_port] <= wr_byte;
        OFS_CTRL:     ctrl_r[wr_port[0]] <= wr_byte;
        default:      ;
      endcase
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= reg_ok(i_axil_req.araddr) ? {24'h000000, readback(i_axil_req.araddr)}
                                             : 32'h00000000;
      rresp_r  <= reg_ok(i_axil_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axil_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign o_axil_rsp.awready = !aw_held_r && (wr_state_r == WR_COLLECT);
  assign o_axil_rsp.wready  = !w_held_r && (wr_state_r == WR_COLLECT);
  assign o_axil_rsp.bvalid  = (wr_state_r == WR_RESP);
  assign o_axil_rsp.bresp   = bresp_r;
  assign o_axil_rsp.arready = !rvalid_r;
  assign o_axil_rsp.rvalid  = rvalid_r;
  assign o_axil_rsp.rdata   = rdata_r;
  assign o_axil_rsp.rresp   = rresp_r;

  // peripheral buffer drives the first port only while a select is active
  wire periph_sel = i_periph_select_a || i_periph_select_b;
  wire periph_on  = periph_mode_r && periph_sel;

  // per-port source selection and driver enable
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    localparam logic [7:0] ALLOWED = (p == 2) ? C_MACRO_PINS : (p == 3) ? D_ECS_PINS : 8'hff;
    localparam logic [7:0] DEDIC   = (p == 2) ? C_JTAG_PINS : 8'h00;
    wire [7:0] addr_mode = (p < 2) ? ctrl_r[p % 2] : 8'h00;
    wire [7:0] oe_pt     = OE_TERM_MASK[p] & i_oe_term[p];
    wire [7:0] oe_base   = oe_pt | dir_r[p] | (logic_out[p] & ~OE_TERM_MASK[p]);
    wire [7:0] cpu_src   = (addr_mode & i_latched_addr) | (~addr_mode & data_out_r[p]);
    wire [7:0] mux_src   = (logic_out[p] & macro_src[p]) | (~logic_out[p] & cpu_src);
    // undefined enable term: direction bit controls, but a logic output pin drives always
    assign logic_out[p] = LOGIC_OUT_MASK[p] & ALLOWED & ~DEDIC;
    assign macro_src[p] = (p == 0) ? i_macro_group_one :
                          (p == 1) ? ((B_FROM_TWO & i_macro_group_two) |
                                      (~B_FROM_TWO & i_macro_group_one)) :
                          (p == 2) ? (i_macro_group_two & C_MACRO_PINS) :
                                     {5'h00, i_external_chip_selects, 1'b0};
    if (p == 0) begin : g_periph
      assign pin_out_nxt[p] = periph_mode_r ? i_cpu_data : mux_src;
      assign pin_oe_nxt[p]  = periph_mode_r ? {8{periph_on && i_cpu_write}} : oe_base;
    end else begin : g_plain
      assign pin_out_nxt[p] = mux_src & port_mask(2'(p));
      // jtag pins never see this driver
      assign pin_oe_nxt[p]  = oe_base & port_mask(2'(p)) & ~DEDIC;
    end
  end

  // pins registered so writes land one edge after the bus write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_out_r  <= '0;
      pin_oe_r   <= '0;
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_out_r  <= pin_out_nxt;
      pin_oe_r   <= pin_oe_nxt;
      pin_meta_r <= i_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign o_pin      = pin_out_r;
  assign o_pin_oe_n = ~pin_oe_r;

  // peripheral read data back toward the processor bus
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      periph_data_r <= 8'h00;
    end else if (periph_on && !i_cpu_write) begin
      periph_data_r <= pin_sync_r[0];
    end
  end

  assign o_periph_data = periph_data_r;

  // input macrocells on the first three ports
  for (genvar m = 0; m < LOGIC_PORTS; m++) begin : g_imc
    input_macrocell #(
      .W          (PORT_W),
      .MODE       (imc_mode_t'(IMC_MODE[m])),
      .USE_STROBE (IMC_STROBE[m])
    ) u_imc (
      .i_clock       (i_clock),
      .i_rst         (i_rst),
      .i_pins        (pin_sync_r[m]),
      .i_addr_strobe (i_addr_strobe),
      .i_term_lo     (i_imc_term[m][0]),
      .i_term_hi     (i_imc_term[m][1]),
      .o_value       (imc_value[m])
    );
  end

  assign o_logic_in = imc_value;

  // checks on the pins and the bus answers
  sequence s_dir_b_write;
    wr_en && !wr_addr_r[7] && (wr_port == 2'd1) && (wr_ofs == OFS_DIR);
  endsequence

  sequence s_data_a_read;
    ar_take && (i_axil_req.araddr == {24'h000000, OFS_DATA_OUT});
  endsequence

  write_to_pin_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      s_dir_b_write ##1 (OE_TERM_MASK[1] == 8'h00) |=>
      (o_pin_oe_n[1] == ~($past(wr_data_r[7:0], 2) | logic_out[1])))
    else $error("direction write did not reach port b driver");

  reset_input_a:
    assert property (@(posedge i_clock) $past(i_rst) |-> (dir_r == '0) && (ctrl_r == '0))
    else $error("configuration not zero after reset");

  dir_output_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (dir_r[1] == 8'hff) |=> (o_pin_oe_n[1] == 8'h00))
    else $error("direction one did not enable port b");

  data_out_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (ctrl_r[1] == 8'h00) && (LOGIC_OUT_MASK[1] == 8'h00) |=>
      (o_pin[1] == $past(data_out_r[1])))
    else $error("port b pins do not follow data out");

  addr_out_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (ctrl_r[0] == 8'hff) && (dir_r[0] == 8'hff) && !periph_mode_r &&
      (LOGIC_OUT_MASK[0] == 8'h00) |=>
      (o_pin[0] == $past(i_latched_addr)) && (o_pin_oe_n[0] == 8'h00))
    else $error("address out not driven on port a");

  jtag_free_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (o_pin_oe_n[2] & C_JTAG_PINS) == C_JTAG_PINS)
    else $error("jtag pin driven by port logic");

  narrow_port_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      (o_pin_oe_n[3][7:3] == 5'h1f) && (dir_r[3][7:3] == 5'h00))
    else $error("fourth port uses bits above three");

  periph_off_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      periph_mode_r && !periph_sel |=> (o_pin_oe_n[0] == 8'hff))
    else $error("peripheral buffer driven without select");

  readback_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      s_data_a_read |=> rvalid_r && (rdata_r == {24'h000000, $past(data_out_r[0])}))
    else $error("readback does not show data out register");

  write_answer_a:
    assert property (@(posedge i_clock) disable iff (i_rst)
      wr_go |=> o_axil_rsp.bvalid && !o_axil_rsp.awready && !o_axil_rsp.wready)
    else $error("write response missing after address and data");

endmodule

// file: pin_partner.sv
// far-side model: external peripherals sharing the port wires
`timescale 1ns/1ps
module pin_partner (
  input  wire logic            i_clock,
  input  wire logic [3:0][7:0] i_pin,
  input  wire logic [3:0][7:0] i_pin_oe_n,
  input  wire logic [3:0][7:0] i_drv,
  input  wire logic [3:0]      i_drv_en,
  input  wire logic            i_addr_hit,
  input  wire logic            i_prog_strobe,
  output logic      [3:0][7:0] o_wire,
  output logic                 o_periph_select_a
);
  logic [7:0] flt_r = 8'h5a;

  // no pull-ups: a released wire wanders, so stale values never look valid
  always_ff @(posedge i_clock) begin
    flt_r <= ~flt_r;
  end

  // select only during program fetch, keeping data space off the buffer
  assign o_periph_select_a = i_addr_hit & i_prog_strobe;

  // wire level from both parties' enables, design side first
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 8; b++) begin
        o_wire[p][b] = !i_pin_oe_n[p][b] ? i_pin[p][b] :
                       i_drv_en[p] ? i_drv[p][b] : flt_r[b];
      end
    end
  end
endmodule

// file: tb_top.sv
// self-checking bench for the programmable i/o ports
`timescale 1ns/1ps
module tb_top;
  import pio_pkg::*;
  logic            i_clock;
  logic            i_rst;
  axil_req_t       req;
  axil_rsp_t       rsp;
  logic [3:0][7:0] o_pin;
  logic [3:0][7:0] oe_n;
  logic [3:0][7:0] wire_lvl;
  logic [3:0][7:0] oe_term;
  logic [3:0][7:0] drv;
  logic [3:0]      drv_en;
  logic [7:0]      lat_addr;
  logic [7:0]      cpu_data;
  logic            cpu_write;
  logic            addr_hit;
  logic            prog_strobe;
  logic            sel_a;
  logic            sel_b;
  logic [7:0]      periph_data;
  logic [2:0][7:0] logic_in;
  int              bad_count;
  int              total_checks;

  // port d pin 0 gets an enable term, pin 1 has none
  programmable_io_ports #(.OE_TERM_MASK({8'h01, 24'h0})) dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_axil_req(req), .o_axil_rsp(rsp),
    .i_pin(wire_lvl), .o_pin(o_pin), .o_pin_oe_n(oe_n), .i_oe_term(oe_term),
    .i_macro_group_one(8'h00), .i_macro_group_two(8'h00),
    .i_external_chip_selects(2'h0), .i_latched_addr(lat_addr),
    .i_addr_strobe(1'b0), .i_imc_term(6'h00), .i_periph_select_a(sel_a),
    .i_periph_select_b(sel_b), .i_cpu_data(cpu_data), .i_cpu_write(cpu_write),
    .o_periph_data(periph_data), .o_logic_in(logic_in));

  pin_partner peer (
    .i_clock(i_clock), .i_pin(o_pin), .i_pin_oe_n(oe_n), .i_drv(drv),
    .i_drv_en(drv_en), .i_addr_hit(addr_hit), .i_prog_strobe(prog_strobe),
    .o_wire(wire_lvl), .o_periph_select_a(sel_a));

  // 50 mhz clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // aw and w offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w, ah, wh, got;
    aw = 1'b0;
    w = 1'b0;
    // start right after a rising edge, whatever the caller last waited on
    @(posedge i_clock);
    req.awaddr <= {24'h0, a};
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(negedge i_clock);
      ah = req.awvalid & rsp.awready;
      wh = req.wvalid & rsp.wready;
      @(posedge i_clock);
      if (ah) begin
        req.awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (wh) begin
        req.wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    req.bready <= 1'b1;
    do begin
      @(negedge i_clock);
      got = rsp.bvalid;
      r = rsp.bresp;
      @(posedge i_clock);
    end while (!got);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    logic got;
    @(posedge i_clock);
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    do begin
      @(negedge i_clock);
      got = rsp.arready;
      @(posedge i_clock);
    end while (!got);
    req.arvalid <= 1'b0;
    req.rready <= 1'b1;
    do begin
      @(negedge i_clock);
      got = rsp.rvalid;
      d = rsp.rdata[7:0];
      r = rsp.rresp;
      @(posedge i_clock);
    end while (!got);
    req.rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({6'h0, r}, {6'h0, RESP_OKAY});
  endtask

  // power-up: direction, data out, port a control and mode registers zero, every pin an input
  task automatic t_reset;
    for (int p = 0; p < 4; p++) begin
      rd_chk(8'(p * 32 + 8), 8'h00);
      rd_chk(8'(p * 32 + 4), 8'h00);
      chk(oe_n[p], 8'hff);
    end
    rd_chk(8'h0c, 8'h00);
    rd_chk(8'h80, 8'h00);
  endtask

  // data out on port b, driver on the edge after the write
  task automatic t_dataout;
    logic [1:0] r;
    wr(8'h24, 8'h5a, r);
    wr(8'h28, 8'hff, r);
    @(negedge i_clock);
    chk(oe_n[1], 8'h00);
    chk(o_pin[1], 8'h5a);
    rd_chk(8'h28, 8'hff);
    rd_chk(8'h30, 8'hff);
    wr(8'h28, 8'h00, r);
    @(negedge i_clock);
    chk(oe_n[1], 8'hff);
  endtask

  // port c inputs seen through data in and the input macrocells
  task automatic t_datain;
    @(posedge i_clock);
    drv[2] <= 8'h3c;
    drv_en[2] <= 1'b1;
    repeat (5) @(posedge i_clock);
    rd_chk(8'h40, 8'h3c);
    chk(logic_in[2], 8'h3c);
    drv_en[2] <= 1'b0;
  endtask

  // enable term ors with direction only where a term exists
  task automatic t_term;
    logic [7:0] d;
    logic [1:0] r;
    wr(8'h64, 8'h01, r);
    oe_term[3] <= 8'h03;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk(oe_n[3], 8'hfe);
    chk({7'h00, o_pin[3][0]}, 8'h01);
    @(posedge i_clock);
    oe_term[3] <= 8'h00;
    wr(8'h68, 8'hff, r);
    rd_chk(8'h68, 8'h07);
    @(posedge i_clock);
    rd(8'h4c, d, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
    wr(8'h6c, 8'hff, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
    wr(8'h68, 8'h00, r);
  endtask

  // address out needs control and direction, control zero falls back
  task automatic t_addr;
    logic [1:0] r;
    lat_addr <= 8'hc3;
    wr(8'h08, 8'hff, r);
    wr(8'h0c, 8'hff, r);
    @(negedge i_clock);
    chk(o_pin[0], 8'hc3);
    chk(oe_n[0], 8'h00);
    wr(8'h0c, 8'h00, r);
    @(negedge i_clock);
    chk(o_pin[0], 8'h00);
    wr(8'h08, 8'h00, r);
  endtask

  // port a as peripheral buffer, closed while select is low
  task automatic t_periph;
    logic [1:0] r;
    wr(8'h80, 8'h80, r);
    rd_chk(8'h80, 8'h80);
    cpu_data <= 8'h96;
    cpu_write <= 1'b1;
    addr_hit <= 1'b1;
    prog_strobe <= 1'b1;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk(o_pin[0], 8'h96);
    chk(oe_n[0], 8'h00);
    @(posedge i_clock);
    prog_strobe <= 1'b0;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk(oe_n[0], 8'hff);
    // the second select alone opens the buffer again
    @(posedge i_clock);
    sel_b <= 1'b1;
    @(posedge i_clock);
    @(negedge i_clock);
    chk(oe_n[0], 8'h00);
    @(posedge i_clock);
    sel_b <= 1'b0;
    cpu_write <= 1'b0;
    prog_strobe <= 1'b1;
    drv[0] <= 8'h69;
    drv_en[0] <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk(oe_n[0], 8'hff);
    chk(periph_data, 8'h69);
    drv_en[0] <= 1'b0;
  endtask

  // direction on the jtag pins only, macrocell input pins left as inputs
  task automatic t_jtag;
    logic [1:0] r;
    wr(8'h48, 8'h63, r);
    @(negedge i_clock);
    chk(oe_n[2], 8'hff);
  endtask

  // reset, then scenarios in turn
  initial begin
    bad_count = 0;
    total_checks = 0;
    req = '0;
    oe_term = '0;
    drv = '0;
    drv_en = '0;
    lat_addr = 8'h00;
    cpu_data = 8'h00;
    cpu_write = 1'b0;
    addr_hit = 1'b0;
    prog_strobe = 1'b0;
    sel_b = 1'b0;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_dataout();
    t_datain();
    t_term();
    t_addr();
    t_jtag();
    t_periph();
    finish_test();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clock);
    bad_count++;
    finish_test();
  end
endmodule
